//--- ipd_demodulator.sv
// Decided for this implementation: the plain strobed port.
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// - narrow counter starts at first selected edge
// - later edge stores complemented narrow count
// - high capture after high, low after low
// - wide count zero wraps to all-ones
// - wrap to all-ones is no time-out
// - first wide edge captures, reloads, starts
// - mode bit zero: edges capture wide count
// - wide capture sets an edge status bit
// - wide capture interrupt only when enabled
// - after a later wide capture reload all-ones, restart
// - reserved run bits ignore writes, read ones
// - sync bit reset-cleared, kept over recovery
// - enable bits start, stop, read running state
module ipd_demodulator (
    // clock and reset
    input  wire logic       core_clk,
    input  wire logic       rst_n,
    // stop-mode recovery pulse
    input  wire logic       stopRecovery,
    // demodulation input pin
    input  wire logic       demodIn,
    // register port
    input  wire logic [3:0] regAddr,
    input  wire logic [7:0] regWrData,
    input  wire logic       regWrite,
    input  wire logic       regRead,
    output logic      [7:0] regRdData,
    // status outputs
    output logic            irq,
    output logic            syncMode
);

    // ========================================
    // register storage
    logic [7:0]  narrowCtrl;
    logic [1:0]  edgeSel;
    logic [1:0]  edgeStat;
    logic [7:0]  wideCtrl;
    logic [7:0]  nRldLow;
    logic [7:0]  nRldHigh;
    logic [7:0]  wRldLow;
    logic [7:0]  wRldHigh;
    logic [7:0]  nCapLow;
    logic [7:0]  nCapHigh;
    logic [15:0] wCap;
    logic [1:0]  intStatus;
    logic [1:0]  intMask;
    logic        syncBit;

    // ========================================
    // write decode and interrupt-status read decode
    wire wrNCtrl = regWrite && regAddr == ipd_pkg::OFS_NARROW_CTRL;
    wire wrCCtrl = regWrite && regAddr == ipd_pkg::OFS_COMMON_CTRL;
    wire wrWCtrl = regWrite && regAddr == ipd_pkg::OFS_WIDE_CTRL;
    wire wrRun   = regWrite && regAddr == ipd_pkg::OFS_RUN_CTRL;
    wire wrNLow  = regWrite && regAddr == ipd_pkg::OFS_NRLD_LOW;
    wire wrNHigh = regWrite && regAddr == ipd_pkg::OFS_NRLD_HIGH;
    wire wrWLow  = regWrite && regAddr == ipd_pkg::OFS_WRLD_LOW;
    wire wrWHigh = regWrite && regAddr == ipd_pkg::OFS_WRLD_HIGH;
    wire wrMask  = regWrite && regAddr == ipd_pkg::OFS_INT_MASK;
    wire rdIntSt = regRead && regAddr == ipd_pkg::OFS_INT_STATUS;

    // ========================================
    // input synchroniser and edge detect
    logic pinMeta;
    logic pinSync;
    logic pinLast;

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            pinMeta <= 1'b0;
            pinSync <= 1'b0;
            pinLast <= 1'b0;
        end else begin
            pinMeta <= demodIn;
            pinSync <= pinMeta;
            pinLast <= pinSync;
        end
    end

    wire riseEdge = pinSync && !pinLast;
    wire fallEdge = !pinSync && pinLast;
    wire bothSel  = edgeSel[1];
    wire selEdge  = (riseEdge && (bothSel || edgeSel == ipd_pkg::EDGE_RISE))
                 || (fallEdge && (bothSel || edgeSel == ipd_pkg::EDGE_FALL));

    // ========================================
    // prescaler, free running
    logic [2:0] preCount;

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            preCount <= ipd_pkg::PRE_RESET;
        end else begin
            preCount <= preCount + 3'h1;
        end
    end

    // divide by 1, 2, 4 or 8 from the two select bits
    function automatic logic tickOf(input logic [1:0] sel,
                                    input logic [2:0] pre);
        logic [2:0] m;
        m = 3'h0;
        case (sel)
            2'h0: m = 3'h0;
            2'h1: m = 3'h1;
            2'h2: m = 3'h3;
            default: m = 3'h7;
        endcase
        return (pre & m) == m;
    endfunction

    wire [1:0] nSel = narrowCtrl[ipd_pkg::CLK_SEL_HI:ipd_pkg::CLK_SEL_LO];
    wire [1:0] wSel = wideCtrl[ipd_pkg::CLK_SEL_HI:ipd_pkg::CLK_SEL_LO];
    wire nTick = tickOf(nSel, preCount);
    wire wTick = tickOf(wSel, preCount);

    // ========================================
    // run control; a write of zero stops, one arms
    wire nRunWr = regWrData[ipd_pkg::RUN_NARROW];
    wire wRunWr = regWrData[ipd_pkg::RUN_WIDE];

    // ========================================
    // narrow counter
    ipd_pkg::ipd_state_type nState;
    logic [7:0] nCount;

    wire nCounting = nState == ipd_pkg::ST_COUNT;
    wire nCapture  = nCounting && selEdge;
    // a falling edge closes a high interval
    wire nCapHighSel = fallEdge;
    wire [7:0] nCapVal = ~nCount;
    wire [7:0] nReload = nCapHighSel ? nRldLow : nRldHigh;

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            nState <= ipd_pkg::ST_IDLE;
        end else if (stopRecovery || (wrRun && !nRunWr)) begin
            nState <= ipd_pkg::ST_IDLE;
        end else if (wrRun && nState == ipd_pkg::ST_IDLE) begin
            nState <= ipd_pkg::ST_ARMED;
        end else if (nState == ipd_pkg::ST_ARMED && selEdge) begin
            nState <= ipd_pkg::ST_COUNT;
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            nCount <= ipd_pkg::BYTE_ONES;
        end else if (nState == ipd_pkg::ST_ARMED && selEdge) begin
            nCount <= pinSync ? nRldHigh : nRldLow;
        end else if (nCapture) begin
            nCount <= nReload;
        end else if (nCounting && nTick) begin
            nCount <= nCount - 8'h01;
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            nCapLow  <= ipd_pkg::REG_RESET;
            nCapHigh <= ipd_pkg::REG_RESET;
        end else if (nCapture && nCapHighSel) begin
            nCapHigh <= nCapVal;
        end else if (nCapture) begin
            nCapLow <= nCapVal;
        end
    end

    // ========================================
    // wide counter
    ipd_pkg::ipd_state_type wState;
    logic [15:0] wCount;

    wire wModeZero = !wideCtrl[ipd_pkg::WIDE_MODE];
    wire wFirst    = wState == ipd_pkg::ST_ARMED && selEdge;
    wire wLater    = wState == ipd_pkg::ST_COUNT && selEdge;
    wire wCapture  = wFirst || (wLater && wModeZero);
    wire wIntEn    = wideCtrl[ipd_pkg::CAP_INT_EN];

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            wState <= ipd_pkg::ST_IDLE;
        end else if (stopRecovery || (wrRun && !wRunWr)) begin
            wState <= ipd_pkg::ST_IDLE;
        end else if (wrRun && wState == ipd_pkg::ST_IDLE) begin
            wState <= ipd_pkg::ST_ARMED;
        end else if (wFirst) begin
            wState <= ipd_pkg::ST_COUNT;
        end
    end

    // zero simply wraps; no time-out flag is touched by that step
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            wCount <= ipd_pkg::WIDE_ONES;
        end else if (wFirst) begin
            wCount <= {wRldHigh, wRldLow};
        end else if (wCapture) begin
            wCount <= ipd_pkg::WIDE_ONES;
        end else if (wState == ipd_pkg::ST_COUNT && wTick) begin
            wCount <= wCount - 16'h0001;
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            wCap <= {ipd_pkg::REG_RESET, ipd_pkg::REG_RESET};
        end else if (wCapture) begin
            wCap <= ~wCount;
        end
    end

    // ========================================
    // control registers
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            narrowCtrl <= ipd_pkg::REG_RESET;
            wideCtrl   <= ipd_pkg::REG_RESET;
            edgeSel    <= 2'h0;
            nRldLow    <= ipd_pkg::REG_RESET;
            nRldHigh   <= ipd_pkg::REG_RESET;
            wRldLow    <= ipd_pkg::REG_RESET;
            wRldHigh   <= ipd_pkg::REG_RESET;
            intMask    <= ipd_pkg::INT_RESET;
        end else begin
            if (wrNCtrl) narrowCtrl <= regWrData;
            if (wrWCtrl) wideCtrl <= regWrData;
            if (wrCCtrl) begin
                edgeSel <= regWrData[ipd_pkg::EDGE_SEL_HI:
                                     ipd_pkg::EDGE_SEL_LO];
            end
            if (wrNLow) nRldLow <= regWrData;
            if (wrNHigh) nRldHigh <= regWrData;
            if (wrWLow) wRldLow <= regWrData;
            if (wrWHigh) wRldHigh <= regWrData;
            if (wrMask) intMask <= regWrData[1:0];
        end
    end

    // only reset or a run write clears sync; stop recovery leaves it alone
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            syncBit <= 1'b0;
        end else if (wrRun) begin
            syncBit <= regWrData[ipd_pkg::RUN_SYNC];
        end
    end

    // ========================================
    // edge status: write one clears, a new capture wins
    wire [1:0] statClr = wrCCtrl ? regWrData[1:0] : 2'h0;
    wire [1:0] statSet;
    assign statSet[ipd_pkg::STAT_RISE] = wCapture && riseEdge;
    assign statSet[ipd_pkg::STAT_FALL] = wCapture && fallEdge;
    wire [1:0] next_edgeStat = (edgeStat & ~statClr) | statSet;

    // ========================================
    // interrupt status: read clears, a new event wins
    wire [1:0] intSet;
    assign intSet[ipd_pkg::INT_NARROW] =
        nCapture && narrowCtrl[ipd_pkg::CAP_INT_EN];
    assign intSet[ipd_pkg::INT_WIDE] = wCapture && wIntEn;
    wire [1:0] next_intStatus = (rdIntSt ? 2'h0 : intStatus) | intSet;

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            edgeStat  <= 2'h0;
            intStatus <= ipd_pkg::INT_RESET;
        end else begin
            edgeStat  <= next_edgeStat;
            intStatus <= next_intStatus;
        end
    end

    // ========================================
    // read path
    wire [7:0] commonRd = {2'h0, edgeSel, 2'h0, edgeStat};
    wire [7:0] runRd = ipd_pkg::RUN_RSVD_ONES
                     | {5'h00, syncBit, nState != ipd_pkg::ST_IDLE,
                        wState != ipd_pkg::ST_IDLE};
    logic [7:0] next_regRdData;

    always_comb begin
        next_regRdData = 8'h00;
        unique case (regAddr)
            ipd_pkg::OFS_NARROW_CTRL: next_regRdData = narrowCtrl;
            ipd_pkg::OFS_COMMON_CTRL: next_regRdData = commonRd;
            ipd_pkg::OFS_WIDE_CTRL:   next_regRdData = wideCtrl;
            ipd_pkg::OFS_RUN_CTRL:    next_regRdData = runRd;
            ipd_pkg::OFS_NRLD_LOW:    next_regRdData = nRldLow;
            ipd_pkg::OFS_NRLD_HIGH:   next_regRdData = nRldHigh;
            ipd_pkg::OFS_WRLD_LOW:    next_regRdData = wRldLow;
            ipd_pkg::OFS_WRLD_HIGH:   next_regRdData = wRldHigh;
            ipd_pkg::OFS_WCAP_LOW:    next_regRdData = wCap[7:0];
            ipd_pkg::OFS_WCAP_HIGH:   next_regRdData = wCap[15:8];
            ipd_pkg::OFS_NCAP_LOW:    next_regRdData = nCapLow;
            ipd_pkg::OFS_NCAP_HIGH:   next_regRdData = nCapHigh;
            ipd_pkg::OFS_INT_STATUS:  next_regRdData = {6'h00, intStatus};
            ipd_pkg::OFS_INT_MASK:    next_regRdData = {6'h00, intMask};
            default:                  next_regRdData = 8'h00;
        endcase
    end

    // ========================================
    // registered outputs
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            regRdData <= 8'h00;
            irq       <= 1'b0;
            syncMode  <= 1'b0;
        end else begin
            regRdData <= regRead ? next_regRdData : 8'h00;
            irq       <= |(intStatus & intMask);
            syncMode  <= syncBit;
        end
    end

endmodule
`default_nettype wire

//--- ipd_pkg.sv
`default_nettype none
package ipd_pkg;
    // register offsets
    localparam logic [3:0] OFS_NARROW_CTRL = 4'h0;
    localparam logic [3:0] OFS_COMMON_CTRL = 4'h1;
    localparam logic [3:0] OFS_WIDE_CTRL   = 4'h2;
    localparam logic [3:0] OFS_RUN_CTRL    = 4'h3;
    localparam logic [3:0] OFS_NRLD_LOW    = 4'h4;
    localparam logic [3:0] OFS_NRLD_HIGH   = 4'h5;
    localparam logic [3:0] OFS_WRLD_LOW    = 4'h6;
    localparam logic [3:0] OFS_WRLD_HIGH   = 4'h7;
    localparam logic [3:0] OFS_WCAP_LOW    = 4'h8;
    localparam logic [3:0] OFS_WCAP_HIGH   = 4'h9;
    localparam logic [3:0] OFS_NCAP_LOW    = 4'ha;
    localparam logic [3:0] OFS_NCAP_HIGH   = 4'hb;
    localparam logic [3:0] OFS_INT_STATUS  = 4'hc;
    localparam logic [3:0] OFS_INT_MASK    = 4'hd;
    // field positions
    localparam int CLK_SEL_LO    = 3;
    localparam int CLK_SEL_HI    = 4;
    localparam int CAP_INT_EN    = 2;
    localparam int EDGE_SEL_LO   = 4;
    localparam int EDGE_SEL_HI   = 5;
    localparam int STAT_RISE     = 1;
    localparam int STAT_FALL     = 0;
    localparam int WIDE_MODE     = 6;
    localparam int RUN_SYNC      = 2;
    localparam int RUN_NARROW    = 1;
    localparam int RUN_WIDE      = 0;
    localparam int INT_NARROW    = 0;
    localparam int INT_WIDE      = 1;
    // values
    localparam logic [7:0]  RUN_RSVD_ONES = 8'hf8;
    localparam logic [7:0]  REG_RESET     = 8'h00;
    localparam logic [7:0]  BYTE_ONES     = 8'hff;
    localparam logic [15:0] WIDE_ONES     = 16'hffff;
    localparam logic [1:0]  EDGE_RISE     = 2'h0;
    localparam logic [1:0]  EDGE_FALL     = 2'h1;
    localparam logic [2:0]  PRE_RESET     = 3'h0;
    localparam logic [1:0]  INT_RESET     = 2'h0;
    typedef enum logic [1:0] {
        ST_IDLE,
        ST_ARMED,
        ST_COUNT
    } ipd_state_type;
endpackage
`default_nettype wire

//--- ipd_pin_source.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================
// far-side signal: toggles the pin on request
module ipd_pin_source (
    // clock and reset
    input  wire logic       core_clk,
    input  wire logic       rst_n,
    // request: toggle after waitLen cycles
    input  wire logic       go,
    input  wire logic [7:0] waitLen,
    // pin and completion
    output logic            demodIn,
    output logic            done
);
    logic [7:0] left;
    logic       busy;
    // level holds between toggles: a driven signal, not a released line
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            demodIn <= 1'b0;
            left    <= 8'h00;
            busy    <= 1'b0;
            done    <= 1'b0;
        end else begin
            done <= 1'b0;
            if (go && !busy) begin
                busy <= 1'b1;
                left <= waitLen;
            end else if (busy) begin
                if (left <= 8'h01) begin
                    demodIn <= !demodIn;
                    busy    <= 1'b0;
                    done    <= 1'b1;
                end else begin
                    left <= left - 8'h01;
                end
            end
        end
    end
endmodule
`default_nettype wire

//--- ipd_demodulator_assertions.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================
// port checker
module ipd_demodulator_assertions (
    input wire logic       core_clk,
    input wire logic       rst_n,
    input wire logic       stopRecovery,
    input wire logic       demodIn,
    input wire logic [3:0] regAddr,
    input wire logic [7:0] regWrData,
    input wire logic       regWrite,
    input wire logic       regRead,
    input wire logic [7:0] regRdData,
    input wire logic       irq,
    input wire logic       syncMode
);
    logic [3:0] sinceEdge;
    logic       lastIn;
    // cycles since the pin last moved, saturating
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            sinceEdge <= 4'hf;
            lastIn    <= 1'b0;
        end else begin
            lastIn    <= demodIn;
            sinceEdge <= (demodIn != lastIn) ? 4'h0 :
                (sinceEdge == 4'hf) ? sinceEdge : sinceEdge + 4'h1;
        end
    end
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rst_n);
    a_rd_idle_zero: assert property (!regRead |=> regRdData == 8'h00)
        else $error("read data not zero outside read");
    a_run_rsvd_ones: assert property (
        regRead && regAddr == ipd_pkg::OFS_RUN_CTRL
        |=> regRdData[7:3] == 5'h1f) else $error("reserved bits not ones");
    a_unmapped_zero: assert property (
        regRead && regAddr > 4'hd |=> regRdData == 8'h00)
        else $error("unmapped read not zero");
    a_sync_set: assert property (
        regWrite && regAddr == ipd_pkg::OFS_RUN_CTRL && regWrData[2]
        |-> ##2 syncMode) else $error("sync bit not set");
    a_sync_clear: assert property (
        regWrite && regAddr == ipd_pkg::OFS_RUN_CTRL && !regWrData[2]
        |-> ##2 !syncMode) else $error("sync bit not cleared");
    a_recovery_keep: assert property (
        stopRecovery && !regWrite && !$past(regWrite)
        |=> $stable(syncMode)) else $error("sync lost on recovery");
    a_run_stop_read: assert property (
        regWrite && regAddr == ipd_pkg::OFS_RUN_CTRL
        && regWrData[1:0] == 2'h0 ##1 regRead
        && regAddr == ipd_pkg::OFS_RUN_CTRL
        |=> regRdData[1:0] == 2'h0) else $error("stopped counter reads on");
    a_irq_cause: assert property (
        // a mask write two cycles back can raise irq with no new edge
        $rose(irq) && !$past(regWrite) && !$past(regWrite, 2)
        |-> sinceEdge inside {[1:8]})
        else $error("irq without recent pin edge");
    a_reset_quiet: assert property (
        $rose(rst_n) |-> !irq && !syncMode && regRdData == 8'h00)
        else $error("outputs not quiet after reset");
    c_wide_read: cover property (regRead && regAddr == ipd_pkg::OFS_WCAP_LOW);
    c_irq_rise: cover property ($rose(irq));
    c_sync_fall: cover property ($fell(syncMode));
endmodule
`default_nettype wire

//--- testbench.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================
// register-level bench
module testbench;
    logic       core_clk, rst_n, stopRecovery, regWrite, regRead, go;
    logic       irq, syncMode, demodIn, done, prevIn;
    logic [3:0] regAddr;
    logic [7:0] regWrData, regRdData, waitLen, rd8, b0, b1;
    logic [15:0] c1;
    int         n_fail, checks_done, cyc, prevRise, lastRise, lastFall, p1;
    initial begin
        core_clk = 1'b0;
        forever #2 core_clk = ~core_clk;
    end
    ipd_demodulator ipd_demodulator_inst (.core_clk(core_clk),
        .rst_n(rst_n), .stopRecovery(stopRecovery), .demodIn(demodIn),
        .regAddr(regAddr), .regWrData(regWrData), .regWrite(regWrite),
        .regRead(regRead), .regRdData(regRdData), .irq(irq),
        .syncMode(syncMode));
    ipd_pin_source ipd_pin_source_inst (.core_clk(core_clk), .rst_n(rst_n),
        .go(go), .waitLen(waitLen), .demodIn(demodIn), .done(done));
    task automatic stop_test();
        $display("checks %0d failures %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge core_clk);
        regAddr <= a; regWrData <= d; regWrite <= 1'b1;
        @(posedge core_clk);
        regWrite <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a, output logic [7:0] d);
        @(posedge core_clk);
        regAddr <= a; regRead <= 1'b1;
        @(posedge core_clk);
        regRead <= 1'b0;
        #1 d = regRdData;
    endtask
    task automatic chk(input string nm, input logic [15:0] e, g);
        checks_done++;
        if (g !== e) begin
            n_fail++;
            $display("ERROR %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic rc(input string nm, input logic [3:0] a, logic [7:0] e);
        rd(a, rd8);
        chk(nm, {8'h00, e}, {8'h00, rd8});
    endtask
    // one pin toggle; wait bounded by the cycle ceiling
    task automatic tog(input logic [7:0] n);
        @(posedge core_clk);
        go <= 1'b1; waitLen <= n;
        @(posedge core_clk);
        go <= 1'b0;
        while (done !== 1'b1) @(posedge core_clk);
    endtask
    // pin edge stamps give the expected widths
    always @(posedge core_clk) begin
        cyc <= cyc + 1;
        prevIn <= demodIn;
        if (demodIn !== prevIn && demodIn === 1'b1) begin
            prevRise <= lastRise;
            lastRise <= cyc;
        end
        if (demodIn !== prevIn && demodIn === 1'b0) lastFall <= cyc;
        if (cyc > 20000) begin
            n_fail++;
            stop_test();
        end
    end
    initial begin
        rst_n = 1'b0; stopRecovery = 1'b0; regWrite = 1'b0; regRead = 1'b0;
        regAddr = 4'h0; regWrData = 8'h00; go = 1'b0; waitLen = 8'h01;
        n_fail = 0; checks_done = 0; cyc = 0; prevIn = 1'b0;
        prevRise = 0; lastRise = 0; lastFall = 0; p1 = 0;
        repeat (12) @(posedge core_clk);
        rst_n <= 1'b1;
        // ==========================================
        // run control
        rc("run reset", ipd_pkg::OFS_RUN_CTRL, 8'hf8);
        wr(ipd_pkg::OFS_RUN_CTRL, 8'h07);
        rc("run all on", ipd_pkg::OFS_RUN_CTRL, 8'hff);
        wr(ipd_pkg::OFS_RUN_CTRL, 8'h04);
        rc("run sync", ipd_pkg::OFS_RUN_CTRL, 8'hfc);
        @(posedge core_clk) stopRecovery <= 1'b1;
        @(posedge core_clk) stopRecovery <= 1'b0;
        repeat (2) @(posedge core_clk);
        chk("sync kept", 16'h1, {15'h0, syncMode});
        rc("unmapped", 4'he, 8'h00);
        wr(ipd_pkg::OFS_RUN_CTRL, 8'h00);
        rc("run off", ipd_pkg::OFS_RUN_CTRL, 8'hf8);
        // ==========================================
        // narrow demodulation, both edges
        wr(ipd_pkg::OFS_NRLD_LOW, 8'hff);
        wr(ipd_pkg::OFS_NRLD_HIGH, 8'hff);
        wr(ipd_pkg::OFS_COMMON_CTRL, 8'h20);
        wr(ipd_pkg::OFS_NARROW_CTRL, 8'h00);
        wr(ipd_pkg::OFS_RUN_CTRL, 8'h02);
        tog(8'd5); tog(8'd40); tog(8'd25);
        repeat (6) @(posedge core_clk);
        rd(ipd_pkg::OFS_NCAP_HIGH, b1); rd(ipd_pkg::OFS_NCAP_LOW, b0);
        chk("narrow diff", 16'(((lastFall - prevRise) - (lastRise - lastFall))
            & 255), {8'h00, b1 - b0});
        rc("run narrow", ipd_pkg::OFS_RUN_CTRL, 8'hfa);
        wr(ipd_pkg::OFS_RUN_CTRL, 8'h00);
        wr(ipd_pkg::OFS_COMMON_CTRL, 8'h03);
        // ==========================================
        // wide demodulation, rising edges
        wr(ipd_pkg::OFS_WRLD_LOW, 8'hff);
        wr(ipd_pkg::OFS_WRLD_HIGH, 8'hff);
        wr(ipd_pkg::OFS_WIDE_CTRL, 8'h04);
        wr(ipd_pkg::OFS_INT_MASK, 8'h02);
        rd(ipd_pkg::OFS_INT_STATUS, rd8);
        wr(ipd_pkg::OFS_RUN_CTRL, 8'h01);
        tog(8'd5); tog(8'd5); tog(8'd20); tog(8'd30);
        repeat (6) @(posedge core_clk);
        p1 = lastRise - prevRise;
        chk("irq on", 16'h1, {15'h0, irq});
        rc("rise status", ipd_pkg::OFS_COMMON_CTRL, 8'h02);
        rd(ipd_pkg::OFS_WCAP_LOW, b0); rd(ipd_pkg::OFS_WCAP_HIGH, b1);
        c1 = {b1, b0};
        rc("int status", ipd_pkg::OFS_INT_STATUS, 8'h02);
        repeat (2) @(posedge core_clk);
        chk("irq cleared", 16'h0, {15'h0, irq});
        tog(8'd10); tog(8'd60);
        repeat (6) @(posedge core_clk);
        rd(ipd_pkg::OFS_WCAP_LOW, b0); rd(ipd_pkg::OFS_WCAP_HIGH, b1);
        chk("wide diff", 16'(lastRise - prevRise - p1),
            {b1, b0} - c1);
        rc("run wide", ipd_pkg::OFS_RUN_CTRL, 8'hf9);
        wr(ipd_pkg::OFS_WIDE_CTRL, 8'h00);
        rd(ipd_pkg::OFS_INT_STATUS, rd8);
        tog(8'd5); tog(8'd5);
        repeat (6) @(posedge core_clk);
        chk("irq disabled", 16'h0, {15'h0, irq});
        // ==========================================
        // mode bit set: later edges leave the capture alone
        wr(ipd_pkg::OFS_WIDE_CTRL, 8'h40);
        rd(ipd_pkg::OFS_WCAP_LOW, b0); rd(ipd_pkg::OFS_WCAP_HIGH, b1);
        c1 = {b1, b0};
        tog(8'd5); tog(8'd9);
        repeat (6) @(posedge core_clk);
        rd(ipd_pkg::OFS_WCAP_LOW, b0); rd(ipd_pkg::OFS_WCAP_HIGH, b1);
        chk("mode hold", c1, {b1, b0});
        rc("run mode", ipd_pkg::OFS_RUN_CTRL, 8'hf9);
        // stop recovery idles the running counter
        @(posedge core_clk) stopRecovery <= 1'b1;
        @(posedge core_clk) stopRecovery <= 1'b0;
        rc("run recovered", ipd_pkg::OFS_RUN_CTRL, 8'hf8);
        // ==========================================
        // reset with the counters stopped clears sync
        wr(ipd_pkg::OFS_RUN_CTRL, 8'h04);
        @(posedge core_clk) rst_n <= 1'b0;
        repeat (3) @(posedge core_clk);
        rst_n <= 1'b1;
        @(posedge core_clk);
        chk("sync reset", 16'h0, {15'h0, syncMode});
        rc("run reset 2", ipd_pkg::OFS_RUN_CTRL, 8'hf8);
        stop_test();
    end
endmodule
bind ipd_demodulator ipd_demodulator_assertions
    ipd_demodulator_assertions_inst (
    .core_clk(core_clk), .rst_n(rst_n), .stopRecovery(stopRecovery),
    .demodIn(demodIn), .regAddr(regAddr), .regWrData(regWrData),
    .regWrite(regWrite), .regRead(regRead), .regRdData(regRdData),
    .irq(irq), .syncMode(syncMode));
`default_nettype wire
